// *** psq_pkg.sv ***
// Shared constants for the pushbutton power sequencer.
package psq_pkg;

	// System clock rate and derived cycles per time unit.
	localparam int CLK_HZ     = 10_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;

	// Documented intervals, each in its own unit.
	localparam int KEY_STAT_MS   = 50;  // Key hold before status goes low.
	localparam int STAT_REL_US   = 900; // Key high to status release.
	localparam int KEY_PUP_MS    = 400; // Key hold to start power-up.
	localparam int KEY_HR_S      = 5;   // Key hold to hard reset (4 s to 6 s).
	localparam int STAT_PW_MS    = 50;  // Status pulse width, at least 40 ms.
	localparam int USB_PUP_MS    = 100; // USB presence to start power-up.
	localparam int EN_PON_US     = 900; // Host enable to power-on.
	localparam int DIS_US        = 1;   // Host disable to regulator off.
	localparam int PUP_DUR_S     = 5;   // Power-up state duration.
	localparam int PDN_DUR_S     = 1;   // Power-down state duration.

	// Width of every interval counter; holds 5 s at the clock rate.
	localparam int CW = 26;

	// Synchroniser depth on every pin input.
	localparam int SYNC_W = 2;

	// Sequencer states, one-hot.
	typedef enum logic [6:0] {
		ST_OFF        = 7'h01,
		ST_HARD_RESET = 7'h02,
		ST_RAMPUP_A   = 7'h04,
		ST_RAMPUP_B   = 7'h08,
		ST_ACTIVE     = 7'h10,
		ST_RAMPDOWN_A = 7'h20,
		ST_RAMPDOWN_B = 7'h40
	} psq_state_t;

endpackage : psq_pkg

// *** psq_sequencer.sv ***
// Pushbutton power sequencer: key timing, status output and regulator state machine.
//
// Notes on behaviour
// - Power-up and active states: status low after key held 50 ms.
// - Active: status releases 900 us after key high.
// - Idle states: key held 400 ms starts power-up.
// - Power-up and active states: key held 5 s forces hard reset.
// - Status low pulses last at least 50 ms.
// - Idle states: USB present 100 ms starts power-up.
// - Off: host enable high 900 us gives active.
// - Active: switcher off within 1 us of its enable low.
// - Active: linear off within 1 us of its enable low.
// - Each power-up state times out after 5 s; the timer restarts on entering the second.
// - Each power-down state lasts 1 s.
// - Order select picks first regulator; second follows.
// - Status is open-drain debounced copy of key.
`timescale 1ns/1ps
`default_nettype none

module psq_sequencer
	import psq_pkg::*;
#(
	// Cycle counts; shorten these in simulation.
	parameter int KEY_STAT_CYC = KEY_STAT_MS * CYC_PER_MS,
	parameter int STAT_REL_CYC = STAT_REL_US * CYC_PER_US,
	parameter int KEY_PUP_CYC  = KEY_PUP_MS * CYC_PER_MS,
	parameter int KEY_HR_CYC   = KEY_HR_S * 1000 * CYC_PER_MS,
	parameter int STAT_PW_CYC  = STAT_PW_MS * CYC_PER_MS,
	parameter int USB_PUP_CYC  = USB_PUP_MS * CYC_PER_MS,
	parameter int EN_PON_CYC   = EN_PON_US * CYC_PER_US,
	parameter int PUP_DUR_CYC  = PUP_DUR_S * 1000 * CYC_PER_MS,
	parameter int PDN_DUR_CYC  = PDN_DUR_S * 1000 * CYC_PER_MS
) (
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	// Pushbutton and USB presence pins.
	input  wire logic       key_n_i,
	input  wire logic       usb_present_i,
	// Host regulator enables and order strap.
	input  wire logic       switcher_enable_i,
	input  wire logic       linear_reg_enable_i,
	input  wire logic       startup_order_sel_i,
	// Regulator feedback near regulation.
	input  wire logic       switcher_near_reg_i,
	input  wire logic       linear_near_reg_i,
	// Open-drain key status pin.
	output logic            key_status_out_o,
	output logic            key_status_oe_o,
	// Regulator enables to the analog side.
	output logic            switcher_on_o,
	output logic            linear_on_o,
	// Current state, one-hot.
	output logic [6:0]      state_o
);

	// Bound from a host enable going low to its regulator off; no logic reads it.
	localparam int DIS_CYC = DIS_US * CYC_PER_US;

	// Synchroniser stages; only the last stage is read by logic.
	logic [SYNC_W-1:0] key_s_q;
	logic [SYNC_W-1:0] usb_s_q;
	logic [SYNC_W-1:0] swe_s_q;
	logic [SYNC_W-1:0] lne_s_q;
	logic [SYNC_W-1:0] ord_s_q;
	logic [SYNC_W-1:0] swr_s_q;
	logic [SYNC_W-1:0] lnr_s_q;

	// Synchronised levels.
	logic key_low;
	logic usb_on;
	logic sw_en;
	logic ln_en;
	logic ord_lin;
	logic sw_near;
	logic ln_near;

	// Interval counters.
	logic [CW-1:0] key_low_q;  // Key held low.
	logic [CW-1:0] key_high_q; // Key held high.
	logic [CW-1:0] usb_q;      // USB present.
	logic [CW-1:0] en_q;       // A host enable high.
	logic [CW-1:0] st_q;       // Time in current timed state.
	logic [CW-1:0] pw_q;       // Status low time.

	// State and output registers.
	psq_state_t state_q;
	psq_state_t state_d;
	logic       stat_low_q;
	logic       sw_on_q;
	logic       ln_on_q;

	// Saturating increment, or restart when the condition is broken.
	function automatic logic [CW-1:0] tick(input logic [CW-1:0] c, input logic run);
		if (!run) begin
			return '0;
		end
		return (&c) ? c : c + CW'(1);
	endfunction : tick

	// True once a counter reaches the given cycle count.
	function automatic logic reached(input logic [CW-1:0] c, input int n);
		return c >= CW'(n);
	endfunction : reached

	// Two-flop synchronisers on every pin; the strap is sampled the same way.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			key_s_q <= '1;
			usb_s_q <= '0;
			swe_s_q <= '0;
			lne_s_q <= '0;
			ord_s_q <= '0;
			swr_s_q <= '0;
			lnr_s_q <= '0;
		end else begin
			key_s_q <= {key_s_q[0], key_n_i};
			usb_s_q <= {usb_s_q[0], usb_present_i};
			swe_s_q <= {swe_s_q[0], switcher_enable_i};
			lne_s_q <= {lne_s_q[0], linear_reg_enable_i};
			ord_s_q <= {ord_s_q[0], startup_order_sel_i};
			swr_s_q <= {swr_s_q[0], switcher_near_reg_i};
			lnr_s_q <= {lnr_s_q[0], linear_near_reg_i};
		end
	end

	// Levels taken from the second stage only.
	assign key_low = !key_s_q[SYNC_W-1];
	assign usb_on  = usb_s_q[SYNC_W-1];
	assign sw_en   = swe_s_q[SYNC_W-1];
	assign ln_en   = lne_s_q[SYNC_W-1];
	assign ord_lin = ord_s_q[SYNC_W-1];
	assign sw_near = swr_s_q[SYNC_W-1];
	assign ln_near = lnr_s_q[SYNC_W-1];

	// Input interval counters; each restarts as soon as its condition breaks.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			key_low_q  <= '0;
			key_high_q <= '0;
			usb_q      <= '0;
			en_q       <= '0;
		end else begin
			key_low_q  <= tick(key_low_q, key_low);
			key_high_q <= tick(key_high_q, !key_low);
			usb_q      <= tick(usb_q, usb_on);
			en_q       <= tick(en_q, sw_en || ln_en);
		end
	end

	// State timer: runs in every state and restarts on every state change.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st_q <= '0;
		end else begin
			st_q <= tick(st_q, state_d == state_q);
		end
	end

	// Next-state logic.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_OFF, ST_HARD_RESET: begin
				// Key hold or USB starts power-up; a key still down from a hard reset must be let go first.
				if ((reached(key_low_q, KEY_PUP_CYC) && !reached(key_low_q, KEY_HR_CYC))
				    || reached(usb_q, USB_PUP_CYC)) begin
					state_d = ST_RAMPUP_A;
				end else if (state_q == ST_OFF && reached(en_q, EN_PON_CYC)) begin
					// Host enable held in off goes straight to active.
					state_d = ST_ACTIVE;
				end
			end
			ST_RAMPUP_A, ST_RAMPUP_B: begin
				// A long press overrides the power-up sequence.
				if (reached(key_low_q, KEY_HR_CYC)) begin
					state_d = ST_HARD_RESET;
				end else if (state_q == ST_RAMPUP_A && (ord_lin ? ln_near : sw_near)) begin
					// First regulator near regulation: bring up the second.
					state_d = ST_RAMPUP_B;
				end else if (reached(st_q, PUP_DUR_CYC)) begin
					// Host must have taken over an enable by now, else power down.
					state_d = (sw_en || ln_en) ? ST_ACTIVE : ST_RAMPDOWN_A;
				end
			end
			ST_ACTIVE: begin
				if (reached(key_low_q, KEY_HR_CYC)) begin
					state_d = ST_HARD_RESET;
				end else if (!sw_en && !ln_en) begin
					// Host dropped both enables: begin power-down.
					state_d = ST_RAMPDOWN_A;
				end
			end
			ST_RAMPDOWN_A: begin
				if (reached(st_q, PDN_DUR_CYC)) begin
					state_d = ST_RAMPDOWN_B;
				end
			end
			ST_RAMPDOWN_B: begin
				if (reached(st_q, PDN_DUR_CYC)) begin
					state_d = ST_OFF;
				end
			end
			default: begin
				// Illegal code recovers to off.
				state_d = ST_OFF;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// Regulator enables. Host enables act through the synchroniser and one flop,
	// three cycles in all, well inside the disable bound of DIS_CYC cycles.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sw_on_q <= 1'b0;
			ln_on_q <= 1'b0;
		end else begin
			unique case (state_d)
				ST_RAMPUP_A: begin
					// Only the regulator picked by the order strap.
					sw_on_q <= !ord_lin;
					ln_on_q <= ord_lin;
				end
				ST_RAMPUP_B: begin
					sw_on_q <= 1'b1;
					ln_on_q <= 1'b1;
				end
				ST_ACTIVE: begin
					sw_on_q <= sw_en;
					ln_on_q <= ln_en;
				end
				default: begin
					// Off, hard reset and power-down keep both regulators off.
					sw_on_q <= 1'b0;
					ln_on_q <= 1'b0;
				end
			endcase
		end
	end

	// Status pulse width counter; runs only while status is held low.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pw_q <= '0;
		end else begin
			pw_q <= tick(pw_q, stat_low_q);
		end
	end

	// Debounced status: asserted after a qualified hold in the on or up states,
	// released only after the minimum width and a settled release of the key.
	// Release is allowed in any state so the pin never sticks low after a reset.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			stat_low_q <= 1'b0;
		end else if (!stat_low_q) begin
			if ((state_q == ST_ACTIVE || state_q == ST_RAMPUP_A || state_q == ST_RAMPUP_B)
			    && reached(key_low_q, KEY_STAT_CYC)) begin
				stat_low_q <= 1'b1;
			end
		end else if (reached(pw_q, STAT_PW_CYC) && reached(key_high_q, STAT_REL_CYC)) begin
			stat_low_q <= 1'b0;
		end
	end

	// Open-drain pin: data is always low, enable drives it.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			key_status_out_o <= 1'b0;
			key_status_oe_o  <= 1'b0;
		end else begin
			key_status_out_o <= 1'b0;
			key_status_oe_o  <= stat_low_q;
		end
	end

	// Registered outputs.
	assign switcher_on_o = sw_on_q;
	assign linear_on_o   = ln_on_q;
	assign state_o       = state_q;

endmodule : psq_sequencer

`default_nettype wire

// *** psq_props.sv ***
// Port-level assertions for the pushbutton power sequencer.
`timescale 1ns/1ps
`default_nettype none
module psq_props
	import psq_pkg::*;
#(
	parameter int PUP_DUR_CYC = 60, // Power-up state length in cycles.
	parameter int PDN_DUR_CYC = 15  // Power-down state length in cycles.
) (
	input wire logic       clk_i,
	input wire logic       rstn_i,
	input wire logic       key_n_i,
	input wire logic       switcher_enable_i,
	input wire logic       linear_reg_enable_i,
	input wire logic       startup_order_sel_i,
	input wire logic       key_status_out_o,
	input wire logic       key_status_oe_o,
	input wire logic       switcher_on_o,
	input wire logic       linear_on_o,
	input wire logic [6:0] state_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	logic [6:0]  st_q;    // State seen one cycle ago.
	logic [25:0] dwell_q; // Cycles in the present state.
	// Dwell restarts on every state change, so a stuck timer shows up at the exit.
	always_ff @(posedge clk_i) begin
		st_q    <= state_o;
		dwell_q <= (!rstn_i || state_o != st_q) ? 26'h0 : dwell_q + 26'h1;
	end
	sequence s_leave_pdn;
		state_o == ST_RAMPDOWN_A ##1 state_o != ST_RAMPDOWN_A;
	endsequence
	sequence s_leave_pdn_b;
		state_o == ST_RAMPDOWN_B ##1 state_o != ST_RAMPDOWN_B;
	endsequence
	sequence s_leave_pup;
		state_o == ST_RAMPUP_B ##1 state_o != ST_RAMPUP_B;
	endsequence
	a_status_od_low: assert property (key_status_out_o == 1'b0)
		else $error("status data not low");
	// The pin is seen two flops, the counter one and the status two more behind the key.
	a_stat_on_hold: assert property ($rose(key_status_oe_o) |-> $past(key_n_i, 5) == 1'b0
		&& $past(state_o, 2) inside {ST_RAMPUP_A, ST_RAMPUP_B, ST_ACTIVE})
		else $error("status asserted without a held key");
	a_pulse_min_width: assert property ($rose(key_status_oe_o) |-> key_status_oe_o [*8])
		else $error("status pulse too short");
	a_release_key_high: assert property ($fell(key_status_oe_o) |-> $past(key_n_i, 5))
		else $error("status released with key low");
	a_sw_disable_fast: assert property ($fell(switcher_enable_i) && state_o == ST_ACTIVE |-> ##[1:10] !switcher_on_o)
		else $error("switcher not disabled in time");
	a_ln_disable_fast: assert property ($fell(linear_reg_enable_i) && state_o == ST_ACTIVE |-> ##[1:10] !linear_on_o)
		else $error("linear not disabled in time");
	a_first_reg_order: assert property (state_o == ST_RAMPUP_A |-> switcher_on_o != startup_order_sel_i
		&& linear_on_o == startup_order_sel_i)
		else $error("wrong first regulator");
	a_hard_reset_hold: assert property ($rose(state_o == ST_HARD_RESET) |-> $past(key_n_i, 4) == 1'b0
		&& !switcher_on_o && !linear_on_o)
		else $error("hard reset without held key");
	a_pup_origin: assert property ($rose(state_o == ST_RAMPUP_A) |-> $past(state_o) inside {ST_OFF, ST_HARD_RESET})
		else $error("power-up entered from wrong state");
	a_active_origin: assert property ($rose(state_o == ST_ACTIVE) |->
		$past(state_o) inside {ST_OFF, ST_RAMPUP_A, ST_RAMPUP_B})
		else $error("active entered from wrong state");
	a_pdn_dwell_len: assert property (s_leave_pdn |-> $past(dwell_q) inside {[PDN_DUR_CYC-4:PDN_DUR_CYC]})
		else $error("power-down length wrong");
	a_pdn_b_dwell: assert property (s_leave_pdn_b |-> $past(dwell_q) inside {[PDN_DUR_CYC-4:PDN_DUR_CYC]})
		else $error("second power-down length wrong");
	a_pup_dwell_len: assert property (s_leave_pup |-> state_o == ST_HARD_RESET || $past(dwell_q) >= PUP_DUR_CYC-4)
		else $error("power-up left too early");
endmodule : psq_props
bind psq_sequencer psq_props #(.PUP_DUR_CYC(PUP_DUR_CYC), .PDN_DUR_CYC(PDN_DUR_CYC)) u_props (
	.clk_i(clk_i), .rstn_i(rstn_i), .key_n_i(key_n_i), .switcher_enable_i(switcher_enable_i),
	.linear_reg_enable_i(linear_reg_enable_i), .startup_order_sel_i(startup_order_sel_i),
	.key_status_out_o(key_status_out_o), .key_status_oe_o(key_status_oe_o),
	.switcher_on_o(switcher_on_o), .linear_on_o(linear_on_o), .state_o(state_o));
`default_nettype wire

// *** psq_reg_model.sv ***
// Model of the two regulators' near-regulation feedback.
`timescale 1ns/1ps
`default_nettype none
module psq_reg_model #(
	parameter int DLY = 6 // Soft-start cycles to near regulation.
) (
	input  wire logic clk_i,
	input  wire logic switcher_on_i,
	input  wire logic linear_on_i,
	output logic      switcher_near_o,
	output logic      linear_near_o
);
	int sw_c;
	int ln_c;
	// Feedback rises only after a steady enable and drops at once when disabled.
	always_ff @(posedge clk_i) begin
		sw_c <= !switcher_on_i ? 0 : (sw_c < DLY) ? sw_c + 1 : DLY;
		ln_c <= !linear_on_i ? 0 : (ln_c < DLY) ? ln_c + 1 : DLY;
	end
	assign switcher_near_o = (sw_c == DLY);
	assign linear_near_o   = (ln_c == DLY);
endmodule : psq_reg_model
`default_nettype wire

// *** psq_sequencer_tb.sv ***
// Self-checking bench for the pushbutton power sequencer.
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer_tb import psq_pkg::*;;
	localparam int PUP = 20, USB = 10, EN = 4, PUD = 60, PDN = 15, HR = 200;
	logic clk_i, rstn_i, key_n_i, usb_i, sw_en, ln_en, sel, sw_nr, ln_nr, st_oe, st_out, sw_on, ln_on;
	logic [6:0] state;
	int err_count, samples_checked, n;
	psq_sequencer #(.KEY_STAT_CYC(5), .STAT_REL_CYC(3), .KEY_PUP_CYC(PUP), .KEY_HR_CYC(HR), .STAT_PW_CYC(8),
		.USB_PUP_CYC(USB), .EN_PON_CYC(EN), .PUP_DUR_CYC(PUD), .PDN_DUR_CYC(PDN)) dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .key_n_i(key_n_i), .usb_present_i(usb_i),
		.switcher_enable_i(sw_en), .linear_reg_enable_i(ln_en), .startup_order_sel_i(sel),
		.switcher_near_reg_i(sw_nr), .linear_near_reg_i(ln_nr), .key_status_out_o(st_out),
		.key_status_oe_o(st_oe), .switcher_on_o(sw_on), .linear_on_o(ln_on), .state_o(state));
	psq_reg_model #(.DLY(6)) u_reg (.clk_i(clk_i), .switcher_on_i(sw_on), .linear_on_i(ln_on),
		.switcher_near_o(sw_nr), .linear_near_o(ln_nr));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task test_done;
		if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done
	task check(input string nm, input logic [6:0] seen, input logic [6:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Bounded wait for a state; n returns the cycles it took.
	task wait_st(input logic [6:0] st, input int lim);
		n = 0;
		// A state reached on the last allowed cycle still counts; only a real miss ends the run.
		while (state !== st && n <= lim) begin
			@(negedge clk_i);
			n++;
		end
		if (state !== st) begin
			check("state", state, st);
			test_done();
		end
	endtask : wait_st
	function logic [6:0] in_win(input int v, input int lo, input int hi);
		return (v >= lo && v <= hi) ? 7'h01 : 7'h00;
	endfunction : in_win
	// Switcher first when the strap is low, linear first when high.
	function logic [6:0] first_on(input logic s);
		return {5'h00, s, ~s};
	endfunction : first_on
	initial begin
		{err_count, samples_checked, n} = '0;
		{rstn_i, key_n_i, usb_i, sw_en, ln_en, sel} = 6'h30;
		n = $urandom(23404);
		for (int s = 0; s < 2; s++) begin
			sel = s[0]; // Strap only moves under reset.
			rstn_i = 1'b0;
			repeat (10) @(negedge clk_i);
			rstn_i = 1'b1;
			key_n_i = 1'b0;
			wait_st(ST_RAMPUP_A, PUP + 8);
			check("key_pup_time", in_win(n, PUP, PUP + 5), 7'h01);
			check("first_reg", {5'h00, ln_on, sw_on}, first_on(sel));
			repeat (10) @(negedge clk_i);
			check("status_low", {6'h00, st_oe}, 7'h01);
			key_n_i = 1'b1;
			{sw_en, ln_en} = 2'h3; // Host keeps both enables at valid levels.
			wait_st(ST_RAMPUP_B, 12);
			check("both_on", {5'h00, ln_on, sw_on}, 7'h03);
			repeat (12) @(negedge clk_i);
			check("status_rel", {6'h00, st_oe}, 7'h00);
			wait_st(ST_ACTIVE, PUD + 8);
			check("pup_dur", in_win(n + 12, PUD - 3, PUD + 3), 7'h01);
			// Two short presses with a gap must not add up to a status pulse.
			for (int k = 0; k < 2; k++) begin
				key_n_i = 1'b0;
				repeat ($urandom_range(1, 3)) @(negedge clk_i);
				key_n_i = 1'b1;
				@(negedge clk_i);
			end
			repeat (8) @(negedge clk_i);
			check("short_press", {6'h00, st_oe}, 7'h00);
			// A press just long enough to qualify: the key alone would release the
			// status before the minimum width is over, so the width rule shows.
			n = $urandom_range(6, 8);
			key_n_i = 1'b0;
			repeat (n) @(negedge clk_i);
			key_n_i = 1'b1;
			repeat (10 - n) @(negedge clk_i);
			check("pulse_on", {6'h00, st_oe}, 7'h01);
			repeat (6) @(negedge clk_i);
			check("pulse_hold", {6'h00, st_oe}, 7'h01);
			repeat (20) @(negedge clk_i);
			check("pulse_rel", {6'h00, st_oe}, 7'h00);
			if (s == 0) sw_en = 1'b0;
			else ln_en = 1'b0;
			repeat (10) @(negedge clk_i);
			check("one_off", {5'h00, ln_on, sw_on}, s ? 7'h01 : 7'h02);
			{sw_en, ln_en} = 2'h0;
			wait_st(ST_RAMPDOWN_A, 8);
			wait_st(ST_RAMPDOWN_B, PDN + 4);
			check("pdn_dur", in_win(n, PDN - 2, PDN + 2), 7'h01);
			wait_st(ST_OFF, PDN + 4);
			{sw_en, ln_en} = s ? 2'h1 : 2'h2;
			wait_st(ST_ACTIVE, EN + 8);
			check("en_pon", in_win(n, EN, EN + 5), 7'h01);
			{sw_en, ln_en} = 2'h0;
			wait_st(ST_OFF, 2 * PDN + 12);
			usb_i = 1'b1;
			wait_st(ST_RAMPUP_A, USB + 8);
			check("usb_pup", in_win(n, USB, USB + 5), 7'h01);
			{usb_i, sw_en, ln_en} = 3'h3;
			key_n_i = 1'b0;
			wait_st(ST_HARD_RESET, HR + 10);
			check("hr_time", in_win(n, HR - 2, HR + 6), 7'h01);
			check("hr_regs", {5'h00, ln_on, sw_on}, 7'h00);
			{key_n_i, sw_en, ln_en} = 3'h4;
			// The long hold must not bounce straight back into power-up.
			repeat (8) @(negedge clk_i);
			check("hr_hold", state, ST_HARD_RESET);
			check("hr_stat_rel", {6'h00, st_oe}, 7'h00);
			check("stat_data", {6'h00, st_out}, 7'h00);
			// A fresh press powers up out of hard reset.
			key_n_i = 1'b0;
			wait_st(ST_RAMPUP_A, PUP + 8);
			check("hr_pup_time", in_win(n, PUP, PUP + 5), 7'h01);
			key_n_i = 1'b1;
		end
		test_done();
	end
endmodule : psq_sequencer_tb
`default_nettype wire
